// ---- hdl/rtc_counters_consts.vh ----
// Purpose: constants for the dual trimmed counter block
// Assumes: 12-bit APB byte address, 32-bit data
// Notes:   definitions only
`ifndef RTC_COUNTERS_CONSTS_VH
`define RTC_COUNTERS_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_PERSIST_TRIM    12'h000
`define OFS_PERSIST_LOAD    12'h004
`define OFS_PERSIST_MATCH0  12'h008
`define OFS_PERSIST_MATCH1  12'h00c
`define OFS_PERSIST_MATCH2  12'h010
`define OFS_CTRL_STATUS     12'h014
`define OFS_PERSIST_COUNT   12'h040
`define OFS_VOLATILE_TRIM   12'h044
`define OFS_VOLATILE_LOAD   12'h048
`define OFS_VOLATILE_MATCH0 12'h04c
`define OFS_VOLATILE_MATCH1 12'h050
`define OFS_VOLATILE_MATCH2 12'h054
`define OFS_VOLATILE_COUNT  12'h058
`define OFS_IRQ_STATUS      12'h060
`define OFS_IRQ_MASK        12'h064

// ----------------------------------------------------------------
// control and status register fields
// ----------------------------------------------------------------
`define CTL_OSC_EN_BIT      8
`define CTL_VPEND_LSB       16
`define CTL_VPEND_MSB       20
`define CTL_PPEND_LSB       0
`define CTL_PPEND_MSB       4
`define CTL_OSC_EN_RST      1'b0

// pending vector layout per counter: {trim, match2, match1, match0, load}
`define PEND_LOAD           0
`define PEND_MATCH0         1
`define PEND_TRIM           4
`define PEND_W              5

// interrupt status layout: per counter {match2, match1, match0, tick}
`define IRQ_PER_CNT         4
`define IRQ_W               8
`define IRQ_PERSIST_MATCH2  3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_WORD            32'h0000_0000
`define RST_TRIM            16'h0000
`define RST_IRQ             8'h00
`define RST_PEND            5'h00

`endif

// ---- hdl/dual_counter_write_sync.v ----
// Purpose: two trimmed 32-bit counters with load, match and pending bits
// Assumes: 32.768 kHz input is a pin, sampled on pclk (40 MHz)
// Notes:   slow domain is modelled as slow-edge enables on pclk
//
// Operation
// [RULE_01] software waits trim pending clear before writing
// [RULE_02] software waits load pending clear before writing
// [RULE_03] software waits match pending clear before writing
// [RULE_04] writes set pending, tick applies and clears
// [RULE_05] trim divides slow clock by value plus one
// [RULE_06] trim upper sixteen bits read zero
// [RULE_07] trim, load, match survive runtime reset, sleep
// [RULE_08] load value copied into counter next tick
// [RULE_09] three matches per counter raise interrupts
// [RULE_10] persistent third match drives wake request
// [RULE_11] control register resets on hardware reset only
// [RULE_12] volatile pending bits 20..16, 31..21 zero
// [RULE_13] pending zero means register safe to write
// [RULE_14] persistent counts in sleep, volatile halts
// [RULE_15] each counter interrupts on every trimmed tick
// [RULE_16] control bit 8 enables slow clock
// [RULE_17] counter increments per tick, wraps to zero
// [RULE_18] pending handshake keeps written values intact
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "rtc_counters_consts.vh"

module dual_counter_write_sync #(
    parameter ADDR_W = 12,
    parameter CNT_W  = 32,
    parameter TRIM_W = 16
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              ce,
    input  wire              runtime_reset,
    input  wire              sleep,
    input  wire              slow_clk_in,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output wire              pslverr,
    output wire [31:0]       prdata,
    output wire              irq,
    output wire              wake_req
);

    // ------------------------------------------------------------
    // slow clock pin synchroniser and edge detect
    // ------------------------------------------------------------
    reg  slow_meta_r;
    reg  slow_sync_r;
    reg  slow_prev_r;
    wire slow_rise;

    // meta flop feeds only the sync flop; edge detect reads the sync and prev flops only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_meta_r <= 1'b0;
            slow_sync_r <= 1'b0;
            slow_prev_r <= 1'b0;
        end else if (ce) begin
            slow_meta_r <= slow_clk_in;
            slow_sync_r <= slow_meta_r;
            slow_prev_r <= slow_sync_r;
        end
    end

    assign slow_rise = slow_sync_r & ~slow_prev_r;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire        wr_acc;
    wire        setup;
    reg         hit_nxt;
    reg  [31:0] rd_nxt;
    reg  [31:0] prdata_r;
    reg         osc_en_r;
    reg  [`IRQ_W-1:0] irq_st_r;
    reg  [`IRQ_W-1:0] irq_mask_r;
    wire [1:0]  wr_trim;
    wire [1:0]  wr_load;
    wire [5:0]  wr_match;
    wire [2*CNT_W-1:0]  cnt_all;
    wire [2*TRIM_W-1:0] trim_all;
    wire [6*CNT_W-1:0]  match_all;
    wire [2*`PEND_W-1:0] pend_all;
    wire [`IRQ_W-1:0]   ev;

    // zero wait: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign wr_acc  = psel & penable & pwrite & ce;
    assign setup   = psel & ~penable;
    assign pslverr = psel & penable & ~hit_nxt;
    assign prdata  = prdata_r;

    // per-register write strobes
    assign wr_trim[0]  = wr_acc & (paddr == `OFS_PERSIST_TRIM);
    assign wr_trim[1]  = wr_acc & (paddr == `OFS_VOLATILE_TRIM);
    assign wr_load[0]  = wr_acc & (paddr == `OFS_PERSIST_LOAD);
    assign wr_load[1]  = wr_acc & (paddr == `OFS_VOLATILE_LOAD);
    assign wr_match[0] = wr_acc & (paddr == `OFS_PERSIST_MATCH0);
    assign wr_match[1] = wr_acc & (paddr == `OFS_PERSIST_MATCH1);
    assign wr_match[2] = wr_acc & (paddr == `OFS_PERSIST_MATCH2);
    assign wr_match[3] = wr_acc & (paddr == `OFS_VOLATILE_MATCH0);
    assign wr_match[4] = wr_acc & (paddr == `OFS_VOLATILE_MATCH1);
    assign wr_match[5] = wr_acc & (paddr == `OFS_VOLATILE_MATCH2);

    // read mux and address map; load registers are write-only
    always @* begin
        hit_nxt = 1'b1;
        rd_nxt  = `RST_WORD;
        case (paddr)
            `OFS_PERSIST_TRIM:    rd_nxt[TRIM_W-1:0] = trim_all[TRIM_W-1:0]; // RULE_06
            `OFS_VOLATILE_TRIM:   rd_nxt[TRIM_W-1:0] = trim_all[2*TRIM_W-1:TRIM_W]; // RULE_06
            `OFS_PERSIST_LOAD:    rd_nxt = `RST_WORD;
            `OFS_VOLATILE_LOAD:   rd_nxt = `RST_WORD;
            `OFS_PERSIST_MATCH0:  rd_nxt = match_all[0*CNT_W +: CNT_W];
            `OFS_PERSIST_MATCH1:  rd_nxt = match_all[1*CNT_W +: CNT_W];
            `OFS_PERSIST_MATCH2:  rd_nxt = match_all[2*CNT_W +: CNT_W];
            `OFS_VOLATILE_MATCH0: rd_nxt = match_all[3*CNT_W +: CNT_W];
            `OFS_VOLATILE_MATCH1: rd_nxt = match_all[4*CNT_W +: CNT_W];
            `OFS_VOLATILE_MATCH2: rd_nxt = match_all[5*CNT_W +: CNT_W];
            `OFS_PERSIST_COUNT:   rd_nxt = cnt_all[CNT_W-1:0];
            `OFS_VOLATILE_COUNT:  rd_nxt = cnt_all[2*CNT_W-1:CNT_W];
            `OFS_CTRL_STATUS: begin
                rd_nxt[`CTL_VPEND_MSB:`CTL_VPEND_LSB] = pend_all[2*`PEND_W-1:`PEND_W]; // RULE_12
                rd_nxt[`CTL_PPEND_MSB:`CTL_PPEND_LSB] = pend_all[`PEND_W-1:0]; // RULE_13
                rd_nxt[`CTL_OSC_EN_BIT] = osc_en_r;
            end
            `OFS_IRQ_STATUS:      rd_nxt[`IRQ_W-1:0] = irq_st_r;
            `OFS_IRQ_MASK:        rd_nxt[`IRQ_W-1:0] = irq_mask_r;
            default:              hit_nxt = 1'b0;
        endcase
    end

    // read data captured in the setup cycle, so prdata is a flop;
    // a state change in the access cycle shows on the next read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= `RST_WORD;
        end else if (ce && setup) begin
            prdata_r <= pwrite ? `RST_WORD : rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // control register: hardware reset only
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_en_r <= `CTL_OSC_EN_RST; // RULE_11
        end else if (wr_acc && paddr == `OFS_CTRL_STATUS) begin
            osc_en_r <= pwdata[`CTL_OSC_EN_BIT]; // RULE_16
        end
    end

    // ------------------------------------------------------------
    // per-counter datapath
    // ------------------------------------------------------------
    genvar g;
    genvar m;
    generate
        for (g = 0; g < 2; g = g + 1) begin : cntr
            reg  [TRIM_W-1:0] div_r;
            reg  [TRIM_W-1:0] trim_act_r;
            reg  [TRIM_W-1:0] trim_sh_r;
            reg  [CNT_W-1:0]  load_sh_r;
            reg  [CNT_W-1:0]  cnt_r;
            reg  [CNT_W-1:0]  cnt_nxt;
            reg               trim_pend_r;
            reg               load_pend_r;
            wire              run_en;
            wire              tick;
            wire [2:0]        mpend;
            wire [2:0]        mhit;

            // volatile counter is powered down in sleep
            assign run_en = osc_en_r & ((g == 0) | ~sleep); // RULE_14 RULE_16
            // trimmed tick after trim plus one slow edges
            assign tick   = slow_rise & run_en & (div_r == trim_act_r); // RULE_05

            // divider phase
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    div_r <= `RST_TRIM;
                end else if (ce && slow_rise && run_en) begin
                    div_r <= tick ? `RST_TRIM : div_r + 1'b1; // RULE_05
                end
            end

            // next count: pending load wins over increment
            always @* begin
                cnt_nxt = cnt_r + 1'b1; // RULE_17
                if (load_pend_r) begin
                    cnt_nxt = load_sh_r; // RULE_08
                end
            end

            // counter; not touched by runtime reset
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_r <= `RST_WORD;
                end else if (ce && tick) begin
                    cnt_r <= cnt_nxt; // RULE_17 RULE_08
                end
            end

            // trim shadow and active value; applied on a tick only, so a
            // divider never sees a half-written divisor
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    trim_sh_r   <= `RST_TRIM;
                    trim_act_r  <= `RST_TRIM;
                    trim_pend_r <= 1'b0;
                end else if (ce) begin
                    if (wr_trim[g]) begin
                        trim_sh_r   <= pwdata[TRIM_W-1:0];
                        trim_pend_r <= 1'b1; // RULE_04
                    end else if (tick && trim_pend_r) begin
                        trim_pend_r <= 1'b0; // RULE_04 RULE_18
                    end
                    if (tick && trim_pend_r && !wr_trim[g]) begin
                        trim_act_r <= trim_sh_r; // RULE_07
                    end
                end
            end

            // load shadow; a write in a tick cycle stays pending
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    load_sh_r   <= `RST_WORD;
                    load_pend_r <= 1'b0;
                end else if (ce) begin
                    if (wr_load[g]) begin
                        load_sh_r   <= pwdata;
                        load_pend_r <= 1'b1; // RULE_04
                    end else if (tick && load_pend_r) begin
                        load_pend_r <= 1'b0; // RULE_18
                    end
                end
            end

            // three match registers
            for (m = 0; m < 3; m = m + 1) begin : mt
                reg [CNT_W-1:0] sh_r;
                reg [CNT_W-1:0] act_r;
                reg             pend_r;

                always @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        sh_r   <= `RST_WORD;
                        act_r  <= `RST_WORD;
                        pend_r <= 1'b0;
                    end else if (ce) begin
                        if (wr_match[g*3+m]) begin
                            sh_r   <= pwdata;
                            pend_r <= 1'b1; // RULE_04
                        end else if (tick && pend_r) begin
                            act_r  <= sh_r; // RULE_07
                            pend_r <= 1'b0; // RULE_18
                        end
                    end
                end

                // compare against the value the counter is about to take
                assign mhit[m] = tick & (cnt_nxt == act_r); // RULE_09
                assign mpend[m] = pend_r;
                assign match_all[(g*3+m)*CNT_W +: CNT_W] = sh_r;
            end

            assign cnt_all[g*CNT_W +: CNT_W]     = cnt_r;
            assign trim_all[g*TRIM_W +: TRIM_W]  = trim_sh_r;
            assign pend_all[g*`PEND_W +: `PEND_W] = {trim_pend_r, mpend, load_pend_r};
            assign ev[g*`IRQ_PER_CNT +: `IRQ_PER_CNT] = {mhit, tick}; // RULE_15
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    wire [`IRQ_W-1:0] st_clr;

    assign st_clr = (wr_acc && paddr == `OFS_IRQ_STATUS) ? pwdata[`IRQ_W-1:0] : `RST_IRQ;

    // write one to clear; an event in the clear cycle wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_r   <= `RST_IRQ;
            irq_mask_r <= `RST_IRQ;
        end else if (ce) begin
            if (runtime_reset) begin
                irq_st_r   <= `RST_IRQ;
                irq_mask_r <= `RST_IRQ;
            end else begin
                irq_st_r <= (irq_st_r & ~st_clr) | ev; // RULE_09 RULE_15
                if (wr_acc && paddr == `OFS_IRQ_MASK) begin
                    irq_mask_r <= pwdata[`IRQ_W-1:0];
                end
            end
        end
    end

    assign irq = |(irq_st_r & irq_mask_r);

    // ------------------------------------------------------------
    // wake request from the persistent third match
    // ------------------------------------------------------------
    reg wake_r;

    // level, held while the sticky status bit stands, unmasked on purpose
    // since the wake path must work with interrupts masked
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_r <= 1'b0;
        end else if (ce) begin
            wake_r <= irq_st_r[`IRQ_PERSIST_MATCH2]; // RULE_10
        end
    end

    assign wake_req = wake_r;

endmodule

// ---- tb/counter_port_sva.sv ----
// Purpose: port checks for the dual counter block
// Assumes: one clock domain, pclk
// Notes:   attached by bind at the foot
`timescale 1ns/1ps
module counter_port_sva (
    input wire        pclk,
    input wire        presetn,
    input wire        ce,
    input wire        runtime_reset,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire        pready,
    input wire        pslverr,
    input wire [31:0] prdata,
    input wire        irq
);
// ----
// access decode
// ----
// unaligned addresses count as unmapped
wire acc = psel && penable;
wire rd  = acc && !pwrite;
wire ok  = paddr[1:0] == 2'b00 && (paddr <= 12'h014 || paddr == 12'h060 ||
           paddr == 12'h064 || (paddr >= 12'h040 && paddr <= 12'h058));
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
// ----
// properties
// ----
// prdata is loaded at the setup edge, so ce must have been high there
property p_ctl_hi;
    rd && $past(ce) && paddr == 12'h014 |-> prdata[31:21] == 11'h000;
endproperty
a_ctl_hi: assert property (p_ctl_hi) else $error("control high bits set");
sequence s_trim_rd;
    rd && $past(ce) && (paddr == 12'h000 || paddr == 12'h044);
endsequence
property p_trim_hi;
    s_trim_rd |-> prdata[31:16] == 16'h0000;
endproperty
a_trim_hi: assert property (p_trim_hi) else $error("trim high bits set");
property p_load_rd;
    rd && $past(ce) && (paddr == 12'h004 || paddr == 12'h048) |-> prdata == 32'h0;
endproperty
a_load_rd: assert property (p_load_rd) else $error("load register readable");
// runtime reset wins over a mask write in the same cycle; writes are excluded anyway
property p_irq_off;
    runtime_reset && ce && !(acc && pwrite) |=> !irq;
endproperty
a_irq_off: assert property (p_irq_off) else $error("irq after runtime reset");
property p_err_on;
    acc && !ok |-> pslverr;
endproperty
a_err_on: assert property (p_err_on) else $error("no error on unmapped");
property p_err_off;
    !acc || ok |-> !pslverr;
endproperty
a_err_off: assert property (p_err_off) else $error("stray error");
property p_ready;
    psel |-> pready;
endproperty
a_ready: assert property (p_ready) else $error("ready low");
property p_rd_hold;
    acc |=> $stable(prdata);
endproperty
a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule

bind dual_counter_write_sync counter_port_sva counter_port_sva_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .runtime_reset(runtime_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .irq(irq));

// ---- tb/dual_counter_write_sync_bench.sv ----
// Purpose: self-checking bench for the dual counter block
// Assumes: slow input driven far faster than 32.768 kHz
// Notes:   table rows first, then directed cases
`timescale 1ns/1ps
module dual_counter_write_sync_bench;
// ----
// stimulus state
// ----
localparam HALF   = 10; // slow input half period in pclk cycles
localparam TRIM_P = 3;  // persistent trim set by the table
logic        pclk = 1'b0;
logic        presetn = 1'b0;
logic        ce = 1'b1;
logic        runtime_reset = 1'b0;
logic        sleep = 1'b0;
logic        slow_clk_in = 1'b0;
logic        psel = 1'b0;
logic        penable = 1'b0;
logic        pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0;
wire         pready;
wire         pslverr;
wire  [31:0] prdata;
wire         irq;
wire         wake_req;
logic [31:0] rdat;
logic [31:0] c;
logic [31:0] v;
logic        rerr;
int          error_cnt = 0;
int          compares = 0;
int          cyc = 0;
int          t0;
int          n;
typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic        x;
} row_t;
// address, write data, read back, error
row_t rows [8] = '{
    '{12'h014, 32'hffff_ffff, 32'h0000_0100, 1'b0},
    '{12'h000, 32'hffff_0003, 32'h0000_0003, 1'b0},
    '{12'h044, 32'h1234_0000, 32'h0000_0000, 1'b0},
    '{12'h048, 32'h0000_0005, 32'h0000_0000, 1'b0},
    '{12'h008, 32'ha5a5_5a5a, 32'ha5a5_5a5a, 1'b0},
    '{12'h04c, 32'h0000_0007, 32'h0000_0007, 1'b0},
    '{12'h054, 32'hdead_beef, 32'hdead_beef, 1'b0},
    '{12'h018, 32'h0000_1234, 32'h0000_0000, 1'b1}};

dual_counter_write_sync dual_counter_write_sync_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .runtime_reset(runtime_reset),
    .sleep(sleep), .slow_clk_in(slow_clk_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .irq(irq), .wake_req(wake_req));

// ----
// clocks and helpers
// ----
always #12.5 pclk = ~pclk;
// slow input much faster than real so a run stays short
always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % HALF == HALF - 1)
        slow_clk_in <= ~slow_clk_in;
end
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
        error_cnt++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask
// one apb transfer; waits for ready under a bound
task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int m;
    m = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
        @(posedge pclk);
        m++;
    end while (pready !== 1'b1 && m < 16);
    if (m >= 16)
        error_cnt++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task wait_clear(input int b);
    n = 0;
    do begin
        xfer(1'b0, 12'h014, 32'h0);
        n++;
    end while (rdat[b] !== 1'b0 && n < 200);
    chk("pending", 32'h0, {31'h0, rdat[b]});
endtask
task wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 600) begin
        @(negedge pclk);
        n++;
    end
    chk("irq", 32'h1, {31'h0, irq});
endtask
task end_of_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
initial begin
    #(25 * 20000);
    error_cnt++;
    end_of_test;
end

// ----
// main sequence
// ----
initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
        xfer(1'b1, rows[i].a, rows[i].d);
        xfer(1'b0, rows[i].a, 32'h0);
        chk("table data", rows[i].e, rdat);
        chk("table err", {31'h0, rows[i].x}, {31'h0, rerr});
    end
    // load near all ones to see the wrap and time one tick period
    xfer(1'b1, 12'h004, 32'hffff_fffe);
    xfer(1'b0, 12'h014, 32'h0);
    chk("load pend", 32'h1, {31'h0, rdat[0]});
    wait_clear(0);
    xfer(1'b0, 12'h040, 32'h0);
    chk("loaded", 32'hffff_fffe, rdat);
    t0 = 0;
    for (n = 0; n < 300 && rdat !== 32'h0; n++) begin
        xfer(1'b0, 12'h040, 32'h0);
        if (rdat === 32'hffff_ffff && t0 == 0)
            t0 = cyc;
    end
    chk("wrap", 32'h0, rdat);
    chk("span", (TRIM_P + 1) * 2 * HALF / 10, 32'((cyc - t0 + 5) / 10));
    // match one masked in, match two only wakes
    xfer(1'b1, 12'h060, 32'hff);
    wait_clear(2);
    wait_clear(3);
    wait_clear(4);
    xfer(1'b0, 12'h040, 32'h0);
    c = rdat + 32'h3;
    xfer(1'b1, 12'h00c, c);
    xfer(1'b1, 12'h010, c);
    xfer(1'b1, 12'h064, 32'h4);
    wait_irq;
    xfer(1'b0, 12'h060, 32'h0);
    chk("match status", 32'h1, {31'h0, rdat[2]});
    chk("wake", 32'h1, {31'h0, wake_req});
    // fresh tick, then clear well before the next one
    xfer(1'b1, 12'h064, 32'h1);
    xfer(1'b1, 12'h060, 32'hff);
    wait_irq;
    xfer(1'b1, 12'h060, 32'h1);
    @(negedge pclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    @(posedge pclk);
    runtime_reset <= 1'b1;
    @(posedge pclk);
    runtime_reset <= 1'b0;
    xfer(1'b0, 12'h014, 32'h0);
    chk("ctrl kept", 32'h100, rdat);
    xfer(1'b0, 12'h00c, 32'h0);
    chk("match kept", c, rdat);
    sleep <= 1'b1;
    xfer(1'b0, 12'h058, 32'h0);
    v = rdat;
    xfer(1'b0, 12'h040, 32'h0);
    c = rdat;
    repeat (200) @(posedge pclk);
    xfer(1'b0, 12'h058, 32'h0);
    chk("volatile held", v, rdat);
    xfer(1'b0, 12'h040, 32'h0);
    chk("persist runs", 32'h1, {31'h0, rdat !== c});
    sleep <= 1'b0;
    // oscillator off: a pending write must stay pending
    xfer(1'b1, 12'h014, 32'h0);
    wait_clear(18);
    xfer(1'b1, 12'h050, 32'h9);
    repeat (100) @(posedge pclk);
    xfer(1'b0, 12'h014, 32'h0);
    chk("held pend", 32'h0004_0000, rdat);
    xfer(1'b1, 12'h014, 32'h100);
    wait_clear(18);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h014, 32'h0);
    chk("ctrl reset", 32'h0, rdat);
    end_of_test;
end
endmodule
